// ---- logic/fsf_flags.sv ----
// Status flag generation with offset registers behind an APB slave.
//
// The APB slave port and the register addresses are this design's own decisions.
`default_nettype none


module fsf_flags #(
  parameter int DEPTH = fsf_pkg::DEF_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        load_select,
  input  wire logic                        wr_req,
  input  wire logic                        rd_req,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [fsf_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [fsf_pkg::DATA_W-1:0]  pwdata,
  output var  logic [fsf_pkg::DATA_W-1:0]  prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  output var  logic                        full_flag_n,
  output var  logic                        empty_flag_n,
  output var  logic                        almost_full_flag_n,
  output var  logic                        almost_empty_flag_n,
  output var  logic                        half_level_flag_n
);
  import fsf_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // The long default offset must leave room below half of the capacity.
  if (DEPTH < MIN_DEPTH || DEPTH > MAX_DEPTH) begin : g_bad_depth
    $error("DEPTH outside the supported range");
  end

  function automatic logic above(input logic [CW-1:0] lvl, input int lim);
    return int'(lvl) > lim;
  endfunction

  // ---------------------------------------------------------------------------
  // Level counter
  // ---------------------------------------------------------------------------
  fsf_lvl_if #(.CW(CW)) lv ();

  assign lv.wr_req = wr_req;
  assign lv.rd_req = rd_req;

  fsf_level #(
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_level (
    .clk (clk),
    .rst (rst),
    .lv  (lv)
  );

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic          first_word_through_mode;
  logic [CW-1:0] full_ofs;
  logic [CW-1:0] empty_ofs;

  wire           setup    = psel && !penable;
  wire           wr_fire  = psel && penable && pready && pwrite;
  wire           hit_ctrl = (paddr == REG_CTRL);
  wire           hit_fofs = (paddr == REG_FULL_OFS);
  wire           hit_eofs = (paddr == REG_EMPTY_OFS);
  wire           hit_lvl  = (paddr == REG_LEVEL);
  wire           hit_flg  = (paddr == REG_FLAGS);
  wire           mapped   = hit_ctrl || hit_fofs || hit_eofs || hit_lvl || hit_flg;
  wire [CW-1:0]  def_ofs  = load_select ? CW'(OFS_LONG) : CW'(OFS_SHORT);

  // The reset is synchronous, so the load select level may be caught here.
  always_ff @(posedge clk) begin
    if (rst) begin
      first_word_through_mode <= CTRL_FIRST_WORD_THROUGH_MODE_RESET;
      full_ofs                <= def_ofs;
      empty_ofs               <= def_ofs;
    end else if (wr_fire) begin
      if (hit_ctrl) first_word_through_mode <= pwdata[CTRL_FIRST_WORD_THROUGH_MODE_BIT];
      if (hit_fofs) full_ofs  <= pwdata[CW-1:0];
      if (hit_eofs) empty_ofs <= pwdata[CW-1:0];
    end
  end

  logic [DATA_W-1:0] rd_mux;
  wire  [4:0]        flag_vec = {half_level_flag_n, almost_empty_flag_n, almost_full_flag_n,
                                 empty_flag_n, full_flag_n};

  assign rd_mux = hit_ctrl ? DATA_W'(first_word_through_mode) :
                  hit_fofs ? DATA_W'(full_ofs) :
                  hit_eofs ? DATA_W'(empty_ofs) :
                  hit_lvl  ? DATA_W'(lv.count) :
                  hit_flg  ? DATA_W'(flag_vec) : '0;

  // One wait-free access phase: the answer is set up at the setup edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------------
  logic next_full_n;
  logic next_empty_n;
  logic next_af_n;
  logic next_ae_n;
  logic next_hf_n;

  assign next_full_n  = first_word_through_mode ? lv.full : !lv.full;
  assign next_empty_n = first_word_through_mode ? lv.empty : !lv.empty;
  assign next_af_n    = !above(lv.count, DEPTH - int'(full_ofs));
  assign next_ae_n    = !(lv.count < empty_ofs);
  assign next_hf_n    = !above(lv.count, DEPTH / 2);

  // Flags idle in the reset state of an empty memory in standard mode.
  always_ff @(posedge clk) begin
    if (rst) begin
      full_flag_n         <= 1'b1;
      empty_flag_n        <= 1'b0;
      almost_full_flag_n  <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      half_level_flag_n   <= 1'b1;
    end else begin
      full_flag_n         <= next_full_n;
      empty_flag_n        <= next_empty_n;
      almost_full_flag_n  <= next_af_n;
      almost_empty_flag_n <= next_ae_n;
      half_level_flag_n   <= next_hf_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_std_full;
    !first_word_through_mode && lv.full;
  endsequence

  sequence s_first_word_through_mode_room;
    first_word_through_mode && !lv.full;
  endsequence

  sequence s_std_empty;
    !first_word_through_mode && lv.empty;
  endsequence

  sequence s_first_word_through_mode_word;
    first_word_through_mode && !lv.empty;
  endsequence

  property p_std_full;
    @(posedge clk) disable iff (rst) s_std_full |=> !full_flag_n;
  endproperty
  a_std_full: assert property (p_std_full) else $error("full not shown in standard mode");

  property p_first_word_through_mode_room;
    @(posedge clk) disable iff (rst) s_first_word_through_mode_room |=> !full_flag_n;
  endproperty
  a_first_word_through_mode_room: assert property (p_first_word_through_mode_room) else $error("input ready not shown");

  property p_std_empty;
    @(posedge clk) disable iff (rst) s_std_empty |=> !empty_flag_n;
  endproperty
  a_std_empty: assert property (p_std_empty) else $error("empty not shown");

  property p_first_word_through_mode_word;
    @(posedge clk) disable iff (rst) s_first_word_through_mode_word |=> !empty_flag_n;
  endproperty
  a_first_word_through_mode_word: assert property (p_first_word_through_mode_word) else $error("output ready not shown");

  property p_almost_full;
    @(posedge clk) disable iff (rst)
      1'b1 |=> almost_full_flag_n == (int'($past(lv.count)) + int'($past(full_ofs)) <= DEPTH);
  endproperty
  a_almost_full: assert property (p_almost_full) else $error("almost full wrong");

  property p_almost_empty;
    @(posedge clk) disable iff (rst)
      (lv.count < empty_ofs) |=> !almost_empty_flag_n;
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost empty wrong");

  property p_half;
    @(posedge clk) disable iff (rst)
      $rose(above(lv.count, DEPTH / 2)) |=> $fell(half_level_flag_n);
  endproperty
  a_half: assert property (p_half) else $error("half level flag late");

  property p_default_ofs;
    @(posedge clk) disable iff (rst)
      $fell(rst) |-> (full_ofs == ($past(load_select) ? CW'(OFS_LONG) : CW'(OFS_SHORT)))
                     && (empty_ofs == full_ofs);
  endproperty
  a_default_ofs: assert property (p_default_ofs) else $error("default offset wrong");

  property p_apb_answer;
    @(posedge clk) disable iff (rst) (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer not single cycle");

endmodule // fsf_flags

`default_nettype wire

// ---- logic/fsf_level.sv ----
// Word level counter that accepts writes and reads and reports full and empty.
`default_nettype none

module fsf_level #(
  parameter int DEPTH = fsf_pkg::DEF_DEPTH,
  parameter int CW    = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  fsf_lvl_if.lvl    lv
);
  import fsf_pkg::*;

  // A counter narrower than the capacity would wrap and hide the full state.
  if (CW < $clog2(DEPTH + 1)) begin : g_bad_cw
    $error("CW too narrow for DEPTH");
  end

  // ---------------------------------------------------------------------------
  // Level tracking
  // ---------------------------------------------------------------------------
  localparam logic [CW-1:0] TOP = CW'(DEPTH);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire           wr_ok = lv.wr_req && (count != TOP);
  wire           rd_ok = lv.rd_req && (count != '0);

  // A write into a full memory is refused even when a read frees a slot in the
  // same cycle; this keeps the full decision a plain compare.
  assign next_count = (wr_ok && !rd_ok) ? CW'(count + 1'b1) :
                      (rd_ok && !wr_ok) ? CW'(count - 1'b1) : count;

  always_ff @(posedge clk) begin
    if (rst) count <= '0;
    else     count <= next_count;
  end

  assign lv.count = count;
  assign lv.full  = (count == TOP);
  assign lv.empty = (count == '0);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_level_bound;
    @(posedge clk) disable iff (rst) count <= TOP;
  endproperty
  a_level_bound: assert property (p_level_bound) else $error("level above capacity");

  property p_level_step;
    @(posedge clk) disable iff (rst)
      (lv.wr_req && !lv.full && !lv.rd_req) |=> count == CW'($past(count) + 1'b1);
  endproperty
  a_level_step: assert property (p_level_step) else $error("write did not add a word");

  property p_level_drain;
    @(posedge clk) disable iff (rst)
      (lv.rd_req && !lv.empty && !lv.wr_req) |=> count == CW'($past(count) - 1'b1);
  endproperty
  a_level_drain: assert property (p_level_drain) else $error("read did not take a word");

endmodule // fsf_level

`default_nettype wire

// ---- pkg/fsf_lvl_if.sv ----
// Carrier between the flag logic and the word level counter.
`default_nettype none

interface fsf_lvl_if #(
  parameter int CW = 16
);
  logic          wr_req;
  logic          rd_req;
  logic [CW-1:0] count;
  logic          full;
  logic          empty;

  modport lvl (
    input  wr_req,
    input  rd_req,
    output count,
    output full,
    output empty
  );

  modport ctl (
    output wr_req,
    output rd_req,
    input  count,
    input  full,
    input  empty
  );
endinterface : fsf_lvl_if

`default_nettype wire

// ---- pkg/fsf_pkg.sv ----
// Shared constants for the first-in-first-out status flag block.
`default_nettype none

package fsf_pkg;

  // ---------------------------------------------------------------------------
  // Register bus geometry and register byte offsets
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_FULL_OFS  = 12'h004;
  localparam logic [11:0] REG_EMPTY_OFS = 12'h008;
  localparam logic [11:0] REG_LEVEL     = 12'h00C;
  localparam logic [11:0] REG_FLAGS     = 12'h010;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_FIRST_WORD_THROUGH_MODE_BIT  = 0;
  localparam int FLAG_FULL_BIT  = 0;
  localparam int FLAG_EMPTY_BIT = 1;
  localparam int FLAG_AF_BIT    = 2;
  localparam int FLAG_AE_BIT    = 3;
  localparam int FLAG_HALF_BIT  = 4;

  // ---------------------------------------------------------------------------
  // Reset values and sizing
  // ---------------------------------------------------------------------------
  localparam logic        CTRL_FIRST_WORD_THROUGH_MODE_RESET = 1'b0;
  localparam logic [15:0] OFS_SHORT       = 16'h007F;
  localparam logic [15:0] OFS_LONG        = 16'h03FF;
  localparam int          DEF_DEPTH       = 32'h0000_8000;
  localparam int          MIN_DEPTH       = 32'h0000_0800;
  localparam int          MAX_DEPTH       = 32'h0000_8000;

endpackage : fsf_pkg

`default_nettype wire

// ---- testbench/fsf_flags_tb_top.sv ----
// Self-checking bench for the status flag block against a reference model.
`default_nettype none

module fsf_flags_tb_top;
  import fsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int D = 2048;
  logic        clk, rst, load_select, wr_req, rd_req, psel, penable, pwrite;
  logic        wr_go, rd_go, rnd_on, pready, pslverr, e;
  logic        ff_n, ef_n, af_n, ae_n, hf_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] seed = 16'h0014;
  logic [4:0]  mf;
  int          errors, compares, lvl, fo, eo, fw, v;

  fsf_flags #(.DEPTH(D)) DUT (.clk(clk), .rst(rst), .load_select(load_select),
    .wr_req(wr_req), .rd_req(rd_req), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_flag_n(ff_n), .empty_flag_n(ef_n), .almost_full_flag_n(af_n),
    .almost_empty_flag_n(ae_n), .half_level_flag_n(hf_n));
  fsf_peer PEER (.clk(clk), .rst(rst), .wr_go(wr_go), .rd_go(rd_go), .rnd_on(rnd_on),
    .rnd(seed[1:0]), .wr_req(wr_req), .rd_req(rd_req));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // The wait for pready has no limit of its own; the watchdog ends a hung transfer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic w, input logic r, input logic rn, input int n);
    wr_go  <= w;
    rd_go  <= r;
    rnd_on <= rn;
    repeat (n) @(posedge clk);
  endtask

  // ----
  // Reference model: flags lag the level by one edge, as the flag registers do.
  // ----
  always @(posedge clk) begin
    seed <= lfsr(seed);
    if (rst) begin
      lvl <= 0;
      fw  <= 0;
      mf  <= 5'b10101;
      fo  <= load_select ? 1023 : 127;
      eo  <= load_select ? 1023 : 127;
    end else begin
      mf[0] <= fw ? !(lvl < D) : !(lvl == D);
      mf[1] <= fw ? !(lvl > 0) : !(lvl == 0);
      mf[2] <= !(lvl > D - fo);
      mf[3] <= !(lvl < eo);
      mf[4] <= !(lvl > D / 2);
      lvl <= lvl + ((wr_req && lvl < D) ? 1 : 0) - ((rd_req && lvl > 0) ? 1 : 0);
      if (psel && penable && pready && pwrite) begin
        if (paddr == REG_CTRL) fw <= pwdata[0];
        if (paddr == REG_FULL_OFS) fo <= pwdata[11:0];
        if (paddr == REG_EMPTY_OFS) eo <= pwdata[11:0];
      end
    end
  end

  always @(negedge clk) if (!rst) begin
    check(ff_n, mf[0]);
    check(ef_n, mf[1]);
    check(af_n, mf[2]);
    check(ae_n, mf[3]);
    check(hf_n, mf[4]);
  end

  // ----
  // Scenarios
  // ----
  initial begin
    errors      = 0;
    compares    = 0;
    rst         = 1'b1;
    load_select = 1'b0;
    wr_go       = 1'b0;
    rd_go       = 1'b0;
    rnd_on      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_FULL_OFS, 32'h0000_0000);
    check(q, 127);
    apb(1'b0, REG_EMPTY_OFS, 32'h0000_0000);
    check(q, 127);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check(e, 1'b1);
    check(q, 0);
    // Random offsets move the almost thresholds away from the defaults.
    v = int'(seed) % D;
    apb(1'b1, REG_EMPTY_OFS, v);
    apb(1'b0, REG_EMPTY_OFS, 32'h0000_0000);
    check(q, v);
    apb(1'b1, REG_FULL_OFS, int'(seed) % D);
    run(1'b1, 1'b0, 1'b0, D + 4);
    // The level is read only: a write to it must leave the count alone.
    apb(1'b1, REG_LEVEL, 32'h0000_0000);
    apb(1'b0, REG_LEVEL, 32'h0000_0000);
    check(q, D);
    check(e, 1'b0);
    apb(1'b0, REG_FLAGS, 32'h0000_0000);
    check(q, {27'h000_0000, mf});
    run(1'b0, 1'b1, 1'b0, D + 4);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    run(1'b1, 1'b0, 1'b0, D + 4);
    run(1'b1, 1'b1, 1'b1, 1000);
    run(1'b0, 1'b1, 1'b0, D + 4);
    rst         <= 1'b1;
    load_select <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_FULL_OFS, 32'h0000_0000);
    check(q, 1023);
    apb(1'b0, REG_EMPTY_OFS, 32'h0000_0000);
    check(q, 1023);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    check(q, 0);
    run(1'b1, 1'b0, 1'b0, 1100);
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule // fsf_flags_tb_top

`default_nettype wire

// ---- testbench/fsf_peer.sv ----
// Writer and reader model that drives the word request lines.
`default_nettype none

module fsf_peer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_go,
  input  wire logic       rd_go,
  input  wire logic       rnd_on,
  input  wire logic [1:0] rnd,
  output var  logic       wr_req,
  output var  logic       rd_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Requests stay low in reset, so no word can be counted before release.
  always_ff @(posedge clk) begin
    wr_req <= !rst && wr_go && (rnd[0] || !rnd_on);
    rd_req <= !rst && rd_go && (rnd[1] || !rnd_on);
  end
endmodule // fsf_peer

`default_nettype wire
